// ---- shared/dp_cfg.svh ----
// constants for the operand routing, carry and decode datapath
`ifndef DP_CFG_SVH
`define DP_CFG_SVH
// datapath widths
`define DATA_W 16
`define BYTE_W 8
`define REG_ADDR_W 4
// register offsets on the plain register port
`define REG_YELLOW_LIMIT 4'h0
`define REG_RED_LIMIT 4'h1
`define REG_CTRL 4'h2
`define REG_STATUS 4'h3
// reset values of the software registers
`define YELLOW_LIMIT_RST 16'h0100
`define RED_LIMIT_RST 16'h00e0
`define CTRL_RST 16'h0001
// control register field
`define CTRL_CHECK_EN 0
// status register fields
`define ST_WORD_ZERO 0
`define ST_LOW_ZERO 1
`define ST_HIGH_ZERO 2
`define ST_CARRY_EXT 3
`define ST_STATUS_HIT 4
`define ST_SWITCH_HIT 5
`define ST_OVERFLOW 6
`define ST_RED_ZONE 7
// decoded internal register addresses
`define STATUS_REG_ADDR 16'hff00
`define SWITCH_REG_ADDR 16'hff02
// alu mode encoding
`define ALU_MODE_LOGIC 1'b1
`endif

// ---- shared/dp_pkg.sv ----
// types shared by the datapath modules
package dp_pkg;
  // carry input sources
  typedef enum logic [1:0] {
    CARRY_IN_ZERO = 2'b00,
    CARRY_IN_ONE = 2'b01,
    CARRY_IN_IR = 2'b10,
    CARRY_IN_STATUS = 2'b11
  } carry_in_e;
  // carry extension sources
  typedef enum logic [1:0] {
    SEL_WORD_CARRY = 2'b00,
    SEL_BYTE_CARRY = 2'b01,
    SEL_ALU_MSB = 2'b10,
    SEL_STATUS_CARRY = 2'b11
  } carry_sel_e;
  // select fields of one microword
  typedef struct packed {
    logic addrMuxSelect;
    logic resultMuxSelectHi;
    logic resultMuxSelectLo;
    logic operandLowSelect1;
    logic operandLowSelect0;
    logic operandHighSelect1;
    logic operandHighSelect0;
    logic aluLogicArithSelect;
    logic [3:0] aluFunctionSelect;
    carry_in_e carryInLogic;
    carry_sel_e carryOutSelector;
    logic loadResult;
    logic loadAddr;
    logic loadOperand;
  } microword_s;
endpackage : dp_pkg

// ---- hw/dp_alu.sv ----
// sixteen-bit alu with logic and arithmetic modes
`timescale 1ns/100ps
`include "dp_cfg.svh"
module dp_alu #(
  parameter int W = `DATA_W
) (
  input wire logic [W-1:0] a, // a operand
  input wire logic [W-1:0] b, // b operand
  input wire logic logicMode, // high selects logic mode
  input wire logic [3:0] func, // function select
  input wire logic carryIn, // carry input
  output logic [W-1:0] result, // alu output
  output logic wordCarry, // carry out of the msb
  output logic byteCarry // carry out of bit 7
);
  logic [W-1:0] x;
  logic [W-1:0] y;
  logic [W-1:0] logicRes;
  logic [W:0] sum;
  logic [`BYTE_W:0] lowSum;
  // mode, function and carry give 48 functions: 16 logic, 32 arithmetic
  always_comb begin
    x = a;
    y = '0;
    case (func)
      4'h0: begin x = a; y = '0; end
      4'h1: begin x = a | b; y = '0; end
      4'h2: begin x = a | ~b; y = '0; end
      4'h3: begin x = '1; y = '0; end
      4'h4: begin x = a; y = a & ~b; end
      4'h5: begin x = a | b; y = a & ~b; end
      4'h6: begin x = a; y = ~b; end
      4'h7: begin x = a & ~b; y = '1; end
      4'h8: begin x = a; y = a & b; end
      4'h9: begin x = a; y = b; end
      4'ha: begin x = a | ~b; y = a & b; end
      4'hb: begin x = a & b; y = '1; end
      4'hc: begin x = a; y = a; end
      4'hd: begin x = a | b; y = a; end
      4'he: begin x = a | ~b; y = a; end
      default: begin x = a; y = '1; end
    endcase
    case (func)
      4'h0: logicRes = ~a;
      4'h1: logicRes = ~(a | b);
      4'h2: logicRes = ~a & b;
      4'h3: logicRes = '0;
      4'h4: logicRes = ~(a & b);
      4'h5: logicRes = ~b;
      4'h6: logicRes = a ^ b;
      4'h7: logicRes = a & ~b;
      4'h8: logicRes = ~a | b;
      4'h9: logicRes = ~(a ^ b);
      4'ha: logicRes = b;
      4'hb: logicRes = a & b;
      4'hc: logicRes = '1;
      4'hd: logicRes = a | ~b;
      4'he: logicRes = a | b;
      default: logicRes = a;
    endcase
    sum = {1'b0, x} + {1'b0, y} + {{W{1'b0}}, carryIn};
    lowSum = {1'b0, x[`BYTE_W-1:0]} + {1'b0, y[`BYTE_W-1:0]} + {{`BYTE_W{1'b0}}, carryIn};
    result = (logicMode == `ALU_MODE_LOGIC) ? logicRes : sum[W-1:0];
    wordCarry = (logicMode == `ALU_MODE_LOGIC) ? 1'b0 : sum[W];
    byteCarry = (logicMode == `ALU_MODE_LOGIC) ? 1'b0 : lowSum[`BYTE_W];
  end
endmodule : dp_alu

// ---- hw/dp_addr_decode.sv ----
// decode of the bus address register contents
`timescale 1ns/100ps
`include "dp_cfg.svh"
module dp_addr_decode #(
  parameter int W = `DATA_W
) (
  input wire logic [W-1:0] addr, // bus address register value
  input wire logic [W-1:0] yellowLimit, // warning stack limit
  input wire logic [W-1:0] redLimit, // fatal stack limit
  input wire logic checkEnable, // stack checking on
  output logic statusHit, // status register addressed
  output logic switchHit, // switch register addressed
  output logic yellowZone, // below warning limit only
  output logic redZone // below fatal limit
);
  assign statusHit = (addr == W'(`STATUS_REG_ADDR));
  assign switchHit = (addr == W'(`SWITCH_REG_ADDR));
  assign redZone = checkEnable && (addr < redLimit);
  assign yellowZone = checkEnable && (addr < yellowLimit) && !redZone;
endmodule : dp_addr_decode

// ---- hw/datapath_mux_carry_decode.sv ----
// operand routing, carry extension and address decode around the alu
`timescale 1ns/100ps
`include "dp_cfg.svh"
module datapath_mux_carry_decode
  import dp_pkg::*;
#(
  parameter int W = `DATA_W
) (
  input wire logic clk, // processor clock
  input wire logic srst, // synchronous reset
  input wire microword_s uword, // select fields from the sequencer
  input wire logic [W-1:0] busRd, // register file read data
  input wire logic [W-1:0] busData, // system bus data
  input wire logic [W-1:0] operandConstants, // constant for the b input
  input wire logic statusCarryBit, // status register carry
  input wire logic irCarryCond, // carry condition from ir decode
  input wire logic irCondEnable, // ir condition enabled here
  input wire logic [`REG_ADDR_W-1:0] regAddr, // register port address
  input wire logic [W-1:0] regWrData, // register port write data
  input wire logic regWr, // register write strobe
  input wire logic regRd, // register read strobe
  output logic [W-1:0] regRdData, // read data, cycle after strobe
  output logic [W-1:0] resultReg, // data result register
  output logic carryExt, // carry extension of result register
  output logic [W-1:0] busAddr, // bus address register
  output logic [W-1:0] operandReg, // operand b register
  output logic wordZero, // result word is zero
  output logic [1:0] byteZero, // result byte zero, high and low
  output logic statusRegAddrHit, // status register address held
  output logic switchRegAddrHit, // switch register address held
  output logic stackOverflowFlag, // address below a stack limit
  output logic stackRedZone // fatal stack violation
);
  // ************************************************************
  // internal signals
  // ************************************************************
  logic [W-1:0] bIn;
  logic [`BYTE_W-1:0] bLow;
  logic [W-`BYTE_W-1:0] bHigh;
  logic [W-1:0] aluOut;
  logic wordCarry;
  logic byteCarry;
  logic carryIn;
  logic selCarry;
  logic [W-1:0] resultMux;
  logic [W-1:0] next_result;
  logic [W-1:0] next_busAddr;
  logic [1:0] next_byteZero;
  logic [W-1:0] yellowLimit;
  logic [W-1:0] redLimit;
  logic [W-1:0] ctrlReg;
  logic [W-1:0] statusWord;
  logic statusHit;
  logic switchHit;
  logic yellowZone;
  logic redZone;
  logic [1:0] lowSel;
  logic [1:0] highSel;

  assign lowSel = {uword.operandLowSelect1, uword.operandLowSelect0};
  assign highSel = {uword.operandHighSelect1, uword.operandHighSelect0};
  assign bIn = {bHigh, bLow};

  // ************************************************************
  // b operand byte multiplexer
  // ************************************************************
  // low byte select
  always_comb begin
    case (lowSel)
      2'b00: bLow = operandReg[`BYTE_W-1:0];
      2'b01: bLow = operandReg[`BYTE_W-1:0];
      2'b10: bLow = operandReg[W-1:`BYTE_W];
      default: bLow = operandConstants[`BYTE_W-1:0];
    endcase
  end

  // high byte select, combined byte functions
  always_comb begin
    case (highSel)
      2'b00: bHigh = operandReg[W-1:`BYTE_W];
      2'b01: bHigh = {(W-`BYTE_W){operandReg[`BYTE_W-1]}};
      2'b10: bHigh = operandReg[`BYTE_W-1:0];
      default: bHigh = operandConstants[W-1:`BYTE_W];
    endcase
  end

  // ************************************************************
  // carry input and the alu
  // ************************************************************
  // carry input from code and enabled condition
  always_comb begin
    case (uword.carryInLogic)
      CARRY_IN_ZERO: carryIn = 1'b0;
      CARRY_IN_ONE: carryIn = 1'b1;
      CARRY_IN_IR: carryIn = irCondEnable & irCarryCond;
      CARRY_IN_STATUS: carryIn = statusCarryBit;
      default: carryIn = 1'b0;
    endcase
  end

  // alu on register data and b input
  dp_alu #(
    .W(W)
  ) alu (
    .a(busRd),
    .b(bIn),
    .logicMode(uword.aluLogicArithSelect),
    .func(uword.aluFunctionSelect),
    .carryIn(carryIn),
    .result(aluOut),
    .wordCarry(wordCarry),
    .byteCarry(byteCarry)
  );

  always_comb begin
    case (uword.carryOutSelector)
      SEL_WORD_CARRY: selCarry = wordCarry;
      SEL_BYTE_CARRY: selCarry = byteCarry;
      SEL_ALU_MSB: selCarry = aluOut[W-1];
      SEL_STATUS_CARRY: selCarry = statusCarryBit;
      default: selCarry = 1'b0;
    endcase
  end

  // ************************************************************
  // result and address registers
  // ************************************************************
  // result multiplexer with shift right through carry
  always_comb begin
    case ({uword.resultMuxSelectHi, uword.resultMuxSelectLo})
      2'b00: resultMux = busRd;
      2'b01: resultMux = busData;
      2'b10: resultMux = resultReg;
      default: resultMux = {carryExt, resultReg[W-1:1]};
    endcase
  end

  // independent loads of result and address registers
  assign next_result = uword.loadResult ? aluOut : resultReg;
  assign next_busAddr = !uword.loadAddr ? busAddr : (uword.addrMuxSelect ? aluOut : busRd);

  // result register and carry extension
  always_ff @(posedge clk) begin
    if (srst) begin
      resultReg <= '0;
      carryExt <= 1'b0;
    end else if (uword.loadResult) begin
      resultReg <= next_result;
      // carry extension loads with the result
      carryExt <= selCarry;
    end
  end

  // bus address register
  always_ff @(posedge clk) begin
    if (srst) begin
      busAddr <= '0;
    end else begin
      busAddr <= next_busAddr;
    end
  end

  // operand register loads from the result mux
  always_ff @(posedge clk) begin
    if (srst) begin
      operandReg <= '0;
    end else if (uword.loadOperand) begin
      operandReg <= resultMux;
    end
  end

  // ************************************************************
  // zero and address decode
  // ************************************************************
  // per-byte zero detect of the next result
  for (genvar g = 0; g < 2; g++) begin : g_byteZero
    assign next_byteZero[g] = ~|next_result[g*`BYTE_W +: `BYTE_W];
  end

  // zero flags registered beside the result they describe
  always_ff @(posedge clk) begin
    if (srst) begin
      wordZero <= 1'b1;
      byteZero <= 2'b11;
    end else begin
      wordZero <= &next_byteZero;
      byteZero <= next_byteZero;
    end
  end

  // decode runs on the next address register value
  dp_addr_decode #(
    .W(W)
  ) addrDecode (
    .addr(next_busAddr),
    .yellowLimit(yellowLimit),
    .redLimit(redLimit),
    .checkEnable(ctrlReg[`CTRL_CHECK_EN]),
    .statusHit(statusHit),
    .switchHit(switchHit),
    .yellowZone(yellowZone),
    .redZone(redZone)
  );

  // address hit and stack flags aligned with the address register
  always_ff @(posedge clk) begin
    if (srst) begin
      statusRegAddrHit <= 1'b0;
      switchRegAddrHit <= 1'b0;
      stackOverflowFlag <= 1'b0;
      stackRedZone <= 1'b0;
    end else begin
      // hits gate the processor bus response
      statusRegAddrHit <= statusHit;
      switchRegAddrHit <= switchHit;
      // overflow with yellow and red levels
      stackOverflowFlag <= yellowZone | redZone;
      stackRedZone <= redZone;
    end
  end

  // ************************************************************
  // software register port
  // ************************************************************
  // limit and control registers
  always_ff @(posedge clk) begin
    if (srst) begin
      yellowLimit <= W'(`YELLOW_LIMIT_RST);
      redLimit <= W'(`RED_LIMIT_RST);
      ctrlReg <= W'(`CTRL_RST);
    end else if (regWr) begin
      case (regAddr)
        `REG_YELLOW_LIMIT: yellowLimit <= regWrData;
        `REG_RED_LIMIT: redLimit <= regWrData;
        `REG_CTRL: ctrlReg <= regWrData & W'(1 << `CTRL_CHECK_EN);
        default: ;
      endcase
    end
  end

  // status word of the block's own state
  always_comb begin
    statusWord = '0;
    statusWord[`ST_WORD_ZERO] = wordZero;
    statusWord[`ST_LOW_ZERO] = byteZero[0];
    statusWord[`ST_HIGH_ZERO] = byteZero[1];
    statusWord[`ST_CARRY_EXT] = carryExt;
    statusWord[`ST_STATUS_HIT] = statusRegAddrHit;
    statusWord[`ST_SWITCH_HIT] = switchRegAddrHit;
    statusWord[`ST_OVERFLOW] = stackOverflowFlag;
    statusWord[`ST_RED_ZONE] = stackRedZone;
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      regRdData <= '0;
    end else if (regRd) begin
      case (regAddr)
        `REG_YELLOW_LIMIT: regRdData <= yellowLimit;
        `REG_RED_LIMIT: regRdData <= redLimit;
        `REG_CTRL: regRdData <= ctrlReg;
        `REG_STATUS: regRdData <= statusWord;
        default: regRdData <= '0;
      endcase
    end else begin
      regRdData <= '0;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  AST_DUAL_LOAD: assert property (uword.loadResult && uword.loadAddr && uword.addrMuxSelect
      |=> resultReg == busAddr)
    else $error("dual load left result and address different");

  AST_FEEDBACK: assert property (uword.loadOperand && uword.resultMuxSelectHi
      && !uword.resultMuxSelectLo |=> operandReg == $past(resultReg))
    else $error("result feedback into operand register failed");

  AST_CARRY_IN: assert property (uword.carryInLogic == CARRY_IN_IR
      |-> carryIn == (irCondEnable && irCarryCond))
    else $error("carry input does not follow enabled condition");

  AST_BYTE_CARRY: assert property (uword.loadResult && uword.carryOutSelector == SEL_BYTE_CARRY
      |=> carryExt == $past(byteCarry))
    else $error("byte carry not captured");

  AST_MSB_CARRY: assert property (uword.loadResult && uword.carryOutSelector == SEL_ALU_MSB
      |=> carryExt == $past(aluOut[W-1]))
    else $error("alu msb not captured");

  // address mux passes register data on 0
  AST_ADDR_MUX: assert property (uword.loadAddr && !uword.addrMuxSelect
      |=> busAddr == $past(busRd))
    else $error("address mux did not pass read data");

  AST_SHIFT: assert property (uword.loadOperand && uword.resultMuxSelectHi
      && uword.resultMuxSelectLo
      |=> operandReg == {$past(carryExt), $past(resultReg[W-1:1])})
    else $error("shift right through carry wrong");

  AST_SWAP: assert property (lowSel == 2'b10 && highSel == 2'b10
      |-> bIn == {operandReg[`BYTE_W-1:0], operandReg[W-1:`BYTE_W]})
    else $error("byte swap wrong");

  AST_SIGN_EXT: assert property (highSel == 2'b01 && lowSel == 2'b00
      |-> bIn == {{(W-`BYTE_W){operandReg[`BYTE_W-1]}}, operandReg[`BYTE_W-1:0]})
    else $error("sign extension wrong");

  // zero flag tracks the result register
  AST_ZERO: assert property (##1 wordZero == (resultReg == '0))
    else $error("word zero flag disagrees with result");

  // status hit tracks the address register
  AST_STATUS_HIT: assert property (##1 statusRegAddrHit == (busAddr == W'(`STATUS_REG_ADDR)))
    else $error("status address hit disagrees with address register");

  // red zone always counts as overflow
  AST_RED_OVERFLOW: assert property (stackRedZone |-> stackOverflowFlag)
    else $error("red zone without overflow");

  // extension holds when the result does not load
  AST_CARRY_HOLD: assert property (!uword.loadResult |=> $stable(carryExt)
      && $stable(resultReg))
    else $error("carry extension moved without result load");

  // main scenarios
  CVR_DUAL_LOAD: cover property (uword.loadResult && uword.loadAddr);
  CVR_SHIFT: cover property (uword.loadOperand && uword.resultMuxSelectHi
      && uword.resultMuxSelectLo);
  CVR_SWAP: cover property (lowSel == 2'b10 && highSel == 2'b10);
  CVR_RED: cover property (stackRedZone);
endmodule : datapath_mux_carry_decode

// ---- tb/uword_seq.sv ----
// sequencer model that issues one microword every cycle
`timescale 1ns/100ps
module uword_seq
  import dp_pkg::*;
#(
  parameter logic [3:0] ADD_FN = 4'h9, // arithmetic code that gives a plus b plus carry
  parameter logic [3:0] PASS_FN = 4'hf // logic code that passes the a operand
) (
  input wire logic clk, // processor clock
  input wire logic srst, // holds the sequencer idle
  input wire logic [31:0] code, // random selection bits
  output microword_s uword // microword to the datapath
);
  // new select fields after each edge; alu in add or in logic pass of a, chosen by bit 31
  always_ff @(posedge clk) begin
    if (srst) begin
      uword <= '0;
    end else begin
      uword <= microword_s'(code[18:0]);
      uword.aluLogicArithSelect <= code[31];
      uword.aluFunctionSelect <= code[31] ? PASS_FN : ADD_FN;
    end
  end
endmodule : uword_seq

// ---- tb/tb.sv ----
// self-checking bench for the datapath with a reference model
`timescale 1ns/100ps
`include "dp_cfg.svh"
module tb;
  import dp_pkg::*;
  logic clk = 0, srst = 1, quiet = 1;
  logic statusCarryBit = 0, irCarryCond = 0, irCondEnable = 0, regWr = 0, regRd = 0;
  logic [15:0] busRd = '0, busData = '0, operandConstants = '0, regWrData = '0;
  logic [3:0] regAddr = '0;
  logic [31:0] code = '0, seed = 32'h00015e5a;
  microword_s uword;
  logic [15:0] regRdData, resultReg, busAddr, operandReg;
  logic carryExt, wordZero, statusRegAddrHit, switchRegAddrHit, stackOverflowFlag, stackRedZone;
  logic [1:0] byteZero;
  logic [15:0] mRes, mAddr, mOp, mRd, mYel, mRed;
  logic mCe, mCext, mWz, mSh, mWh, mOv, mRz;
  logic [1:0] mBz;
  int cyc = 0, err_total = 0, n_compared = 0;

  // 10 MHz clock
  always #50 clk = ~clk;

  uword_seq i_seq (.clk(clk), .srst(quiet), .code(code), .uword(uword));

  datapath_mux_carry_decode i_dut (.clk(clk), .srst(srst), .uword(uword), .busRd(busRd),
    .busData(busData), .operandConstants(operandConstants), .statusCarryBit(statusCarryBit),
    .irCarryCond(irCarryCond), .irCondEnable(irCondEnable), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .resultReg(resultReg), .carryExt(carryExt), .busAddr(busAddr), .operandReg(operandReg),
    .wordZero(wordZero), .byteZero(byteZero), .statusRegAddrHit(statusRegAddrHit),
    .switchRegAddrHit(switchRegAddrHit), .stackOverflowFlag(stackOverflowFlag),
    .stackRedZone(stackRedZone));

  // xorshift generator
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  // compare and count
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (e !== g) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // verdict and end of run
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize

  // stimulus: reset at start and mid-run, random words otherwise
  always @(posedge clk) begin
    cyc <= cyc + 1;
    srst <= (cyc < 3) || (cyc >= 1500 && cyc < 1502);
    quiet <= (cyc < 6) || (cyc >= 1500 && cyc < 1504);
    seed = xs(seed);
    code <= seed;
    seed = xs(seed);
    // addresses near the hit values and the stack limits
    case (seed[1:0])
      2'd0: busRd <= `STATUS_REG_ADDR;
      2'd1: busRd <= `SWITCH_REG_ADDR;
      2'd2: busRd <= {7'h00, seed[24:16]};
      default: busRd <= seed[31:16];
    endcase
    seed = xs(seed);
    busData <= seed[15:0];
    operandConstants <= seed[31:16];
    seed = xs(seed);
    statusCarryBit <= seed[0];
    irCarryCond <= seed[1];
    irCondEnable <= seed[2];
    regAddr <= {1'b0, seed[6:4]};
    regWrData <= {7'h00, seed[24:16]};
    regWr <= !quiet && seed[8:7] == 2'd0;
    regRd <= !quiet && seed[8:7] == 2'd1;
    if (cyc == 5000) begin
      err_total++;
      summarize();
    end
  end

  // reference model, one step per edge
  always @(posedge clk) begin
    logic [15:0] b, nRes, nAddr;
    logic carryBit, cs;
    int s, sb;
    if (srst) begin
      {mRes, mAddr, mOp, mRd} = '0;
      {mCext, mSh, mWh, mOv, mRz} = '0;
      mWz = 1;
      mBz = 2'b11;
      mYel = `YELLOW_LIMIT_RST;
      mRed = `RED_LIMIT_RST;
      mCe = 1;
    end else begin
      carryBit = uword.carryInLogic[1] ? (uword.carryInLogic[0] ? statusCarryBit :
        irCondEnable & irCarryCond) : uword.carryInLogic[0];
      b[7:0] = uword.operandLowSelect1 ? (uword.operandLowSelect0 ? operandConstants[7:0] :
        mOp[15:8]) : mOp[7:0];
      case ({uword.operandHighSelect1, uword.operandHighSelect0})
        2'b00: b[15:8] = mOp[15:8];
        2'b01: b[15:8] = {8{mOp[7]}};
        2'b10: b[15:8] = mOp[7:0];
        default: b[15:8] = operandConstants[15:8];
      endcase
      // logic mode passes the a operand and gives no carries
      if (uword.aluLogicArithSelect) begin
        s = busRd;
        sb = 0;
      end else begin
        s = busRd + b + carryBit;
        sb = busRd[7:0] + b[7:0] + carryBit;
      end
      case (uword.carryOutSelector)
        SEL_WORD_CARRY: cs = s[16];
        SEL_BYTE_CARRY: cs = sb[8];
        SEL_ALU_MSB: cs = s[15];
        default: cs = statusCarryBit;
      endcase
      case (regAddr)
        `REG_YELLOW_LIMIT: mRd = regRd ? mYel : '0;
        `REG_RED_LIMIT: mRd = regRd ? mRed : '0;
        `REG_CTRL: mRd = regRd ? {15'h0000, mCe} : '0;
        `REG_STATUS: mRd = regRd ? {8'h00, mRz, mOv, mWh, mSh, mCext, mBz, mWz} : '0;
        default: mRd = '0;
      endcase
      // result mux into operand register, old result and carry
      if (uword.loadOperand) begin
        case ({uword.resultMuxSelectHi, uword.resultMuxSelectLo})
          2'b00: mOp = busRd;
          2'b01: mOp = busData;
          2'b10: mOp = mRes;
          default: mOp = {mCext, mRes[15:1]};
        endcase
      end
      // result and carry extension load together
      nRes = uword.loadResult ? s[15:0] : mRes;
      mCext = uword.loadResult ? cs : mCext;
      nAddr = uword.loadAddr ? (uword.addrMuxSelect ? s[15:0] : busRd) : mAddr;
      mRes = nRes;
      mAddr = nAddr;
      mWz = nRes == 16'h0000;
      mBz = {nRes[15:8] == 8'h00, nRes[7:0] == 8'h00};
      mSh = nAddr == `STATUS_REG_ADDR;
      mWh = nAddr == `SWITCH_REG_ADDR;
      mRz = mCe && nAddr < mRed;
      mOv = mCe && (nAddr < mYel || nAddr < mRed);
      if (regWr && regAddr == `REG_YELLOW_LIMIT) mYel = regWrData;
      if (regWr && regAddr == `REG_RED_LIMIT) mRed = regWrData;
      if (regWr && regAddr == `REG_CTRL) mCe = regWrData[`CTRL_CHECK_EN];
    end
  end

  // compare every output once settled
  always @(negedge clk) begin
    if (cyc >= 1) begin
      chk("resultReg", mRes, resultReg);
      chk("busAddr", mAddr, busAddr);
      chk("operandReg", mOp, operandReg);
      chk("carryExt", {15'h0000, mCext}, {15'h0000, carryExt});
      chk("wordZero", {15'h0000, mWz}, {15'h0000, wordZero});
      chk("byteZero", {14'h0000, mBz}, {14'h0000, byteZero});
      chk("statusHit", {15'h0000, mSh}, {15'h0000, statusRegAddrHit});
      chk("switchHit", {15'h0000, mWh}, {15'h0000, switchRegAddrHit});
      chk("overflow", {15'h0000, mOv}, {15'h0000, stackOverflowFlag});
      chk("redZone", {15'h0000, mRz}, {15'h0000, stackRedZone});
      chk("regRdData", mRd, regRdData);
    end
  end

  // main sequence
  initial begin
    wait (cyc == 3000);
    summarize();
  end
endmodule : tb
